// [verilog/ptc_tx_stamp_dev.sv]
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module ptc_tx_stamp_dev
	import ptc_pkg::*;
#(
	parameter int NPORT = 3,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register port
	ptc_reg_if.dev rif,
	// Egress capture from the transmit path
	input wire logic cap_valid,
	input wire logic [1:0] cap_port,
	input wire logic [31:0] cap_sec,
	input wire logic [29:0] cap_ns,
	input wire logic [3:0] cap_kind,
	input wire logic [15:0] cap_seq,
	input wire logic [79:0] cap_src_id,
	// Frame modification request
	input wire logic mod_valid,
	input wire logic [1:0] mod_port,
	input wire logic [3:0] mod_kind,
	input wire logic turnaround_insert_en,
	input wire logic sync_egress_insert_en,
	input wire logic [63:0] mod_corr,
	input wire logic [31:0] mod_rx_sec,
	input wire logic [29:0] mod_rx_ns,
	input wire logic [31:0] mod_tx_sec,
	input wire logic [29:0] mod_tx_ns,
	// Frame modification result
	output logic mod_done,
	output logic [63:0] mod_corr_out,
	output logic udp_checksum_zero,
	// Delay_Resp egress time lookup
	input wire logic resp_valid,
	input wire logic [1:0] resp_port,
	output logic resp_done,
	output logic [3:0] resp_sec,
	output logic [29:0] resp_ns
);
	localparam int PW = $clog2(DEPTH);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [11:0] crc12(input logic [79:0] d);
		logic [11:0] c;
		c = 12'h000;
		for (int i = 79; i >= 0; i--) begin
			if (c[11] ^ d[i]) begin
				c = {c[10:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[10:0], 1'b0};
			end
		end
		return c;
	endfunction
	// ----------------------------------------
	// Register access decode
	// ----------------------------------------
	logic ack_q;
	logic [31:0] rdata_q;
	wire take = rif.req & ~ack_q;
	wire port_ok = {1'b0, rif.port} < 3'(NPORT);
	wire bank_ok = (rif.bank == BANK_PORT) & port_ok;
	wire hit_chk = bank_ok & (rif.addr == OFF_CHK_CLR);
	wire hit_sec = bank_ok & (rif.addr == OFF_EG_SEC);
	wire hit_ns = bank_ok & (rif.addr == OFF_EG_NS);
	wire hit_hdr = bank_ok & (rif.addr == OFF_HDR);
	wire hit_dsec = bank_ok & (rif.addr == OFF_DREQ_SEC);
	wire hit_dns = bank_ok & (rif.addr == OFF_DREQ_NS);
	wire hit_cnt = bank_ok & (rif.addr == OFF_TX_CNT);
	wire wr_chk = take & rif.wr & hit_chk;
	// Reading the header completes an entry and releases it
	wire rd_pop = take & ~rif.wr & hit_hdr;
	wire [11:0] cap_crc = crc12(cap_src_id);
	wire [31:0] cap_hdr = {cap_crc, cap_kind, cap_seq};
	// ----------------------------------------
	// Per-port state
	// ----------------------------------------
	logic [31:0] head_sec [NPORT];
	logic [29:0] head_ns [NPORT];
	logic [31:0] head_hdr [NPORT];
	logic [2:0] cnt_a [NPORT];
	logic [3:0] dsec_a [NPORT];
	logic [29:0] dns_a [NPORT];
	logic chk_a [NPORT];
	genvar p;
	generate
		for (p = 0; p < NPORT; p++) begin : g_port
			logic [31:0] sec_q [DEPTH];
			logic [29:0] ns_q [DEPTH];
			logic [31:0] hdr_q [DEPTH];
			logic [PW-1:0] wp_q;
			logic [PW-1:0] rp_q;
			logic [2:0] cnt_q;
			logic [2:0] cnt_d;
			logic [3:0] dsec_q;
			logic [29:0] dns_q;
			logic chk_q;
			wire mine = cap_valid & (cap_port == 2'(p));
			// Full buffer keeps older captures
			wire push = mine & (cnt_q < 3'(DEPTH));
			wire pop = rd_pop & (rif.port == 2'(p)) & (cnt_q != 3'h0);
			wire sel_rd = rif.port == 2'(p);
			assign cnt_d = cnt_q + {2'h0, push} - {2'h0, pop};
			assign head_sec[p] = sec_q[rp_q];
			assign head_ns[p] = ns_q[rp_q];
			assign head_hdr[p] = hdr_q[rp_q];
			assign cnt_a[p] = cnt_q;
			assign dsec_a[p] = dsec_q;
			assign dns_a[p] = dns_q;
			assign chk_a[p] = chk_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					for (int e = 0; e < DEPTH; e++) begin
						sec_q[e] <= RST_ZERO;
						ns_q[e] <= 30'h0000_0000;
						hdr_q[e] <= RST_ZERO;
					end
					wp_q <= '0;
					rp_q <= '0;
					cnt_q <= 3'h0;
				end else begin
					if (push) begin
						// Time and header share one slot
						sec_q[wp_q] <= cap_sec;
						ns_q[wp_q] <= cap_ns;
						hdr_q[wp_q] <= cap_hdr;
						wp_q <= wp_q + 1'b1;
					end
					if (pop) begin
						rp_q <= rp_q + 1'b1;
					end
					cnt_q <= cnt_d;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					dsec_q <= 4'h0;
					dns_q <= 30'h0000_0000;
					chk_q <= 1'b0;
				end else begin
					// Kept apart from the buffer, never dropped
					if (mine & (cap_kind == KIND_DREQ)) begin
						dsec_q <= cap_sec[3:0];
						dns_q <= cap_ns;
					end
					if (wr_chk & sel_rd) begin
						chk_q <= rif.wdata[CHK_CLR_BIT];
					end
				end
			end
		end
	endgenerate
	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire [1:0] ps = port_ok ? rif.port : 2'h0;
	wire have = cnt_a[ps] != 3'h0;
	// Empty buffer reads zero so stale slots never leak
	wire [31:0] rd_word =
		hit_chk ? {31'h0, chk_a[ps]} :
		hit_sec & have ? head_sec[ps] :
		hit_ns & have ? {2'h0, head_ns[ps]} :
		hit_hdr & have ? head_hdr[ps] :
		hit_dsec ? {28'h0, dsec_a[ps]} :
		hit_dns ? {2'h0, dns_a[ps]} :
		hit_cnt ? {29'h0, cnt_a[ps]} : RST_ZERO;
	assign rif.ack = ack_q;
	assign rif.rdata = rdata_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= 1'b0;
			rdata_q <= RST_ZERO;
		end else begin
			ack_q <= take;
			if (take) begin
				rdata_q <= rif.wr ? RST_ZERO : rd_word;
			end
		end
	end
	// ----------------------------------------
	// Frame modification
	// ----------------------------------------
	wire mp_ok = {1'b0, mod_port} < 3'(NPORT);
	wire [1:0] mp = mp_ok ? mod_port : 2'h0;
	wire ta_ins = turnaround_insert_en & (mod_kind == KIND_PDRESP);
	wire sy_ins = sync_egress_insert_en & (mod_kind == KIND_SYNC);
	wire [63:0] tx_tot = {32'h0, mod_tx_sec} * NS_PER_SEC + {34'h0, mod_tx_ns};
	wire [63:0] rx_tot = {32'h0, mod_rx_sec} * NS_PER_SEC + {34'h0, mod_rx_ns};
	// Correction field counts ns scaled by 2^16
	wire [63:0] ta_cf = (tx_tot - rx_tot) << CF_FRAC_BITS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_done <= 1'b0;
			mod_corr_out <= 64'h0000_0000_0000_0000;
			udp_checksum_zero <= 1'b0;
		end else begin
			mod_done <= mod_valid;
			if (mod_valid) begin
				mod_corr_out <= ta_ins ? mod_corr + ta_cf : mod_corr;
				udp_checksum_zero <= mp_ok & chk_a[mp] & (ta_ins | sy_ins);
			end
		end
	end
	// ----------------------------------------
	// Delay_Resp time lookup
	// ----------------------------------------
	wire rp_ok = {1'b0, resp_port} < 3'(NPORT);
	wire [1:0] rq = rp_ok ? resp_port : 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_done <= 1'b0;
			resp_sec <= 4'h0;
			resp_ns <= 30'h0000_0000;
		end else begin
			resp_done <= resp_valid;
			if (resp_valid) begin
				resp_sec <= rp_ok ? dsec_a[rq] : 4'h0;
				resp_ns <= rp_ok ? dns_a[rq] : 30'h0000_0000;
			end
		end
	end
endmodule

// [inc/ptc_pkg.sv]
// Overview of operation
// - Zero UDP checksum when clear bit and insertion
// - Host keeps clear bit fixed while enabled
// - Four buffered captures per port
// - Three-bit count; data valid when nonzero
// - Seconds 32 bits; nanoseconds 30 bits; Delay_Req seconds kept as bits 3:0 only
// - Header bits 31:20 hold identity CRC
// - Kind 19:16, sequence 15:0, reset zero
// - Header buffered in step with times
// - Keep last Delay_Req egress time per port
// - Feed that time into later Delay_Resp
// - Port registers decode only in bank 2
// - Two-bit port select picks the instance
// - Add turnaround time to Pdelay_Resp correction
package ptc_pkg;
	// ----------------------------------------
	// Device register map
	// ----------------------------------------
	localparam logic [8:0] OFF_CHK_CLR = 9'h168;
	localparam logic [8:0] OFF_EG_SEC = 9'h16c;
	localparam logic [8:0] OFF_EG_NS = 9'h170;
	localparam logic [8:0] OFF_HDR = 9'h174;
	localparam logic [8:0] OFF_DREQ_SEC = 9'h178;
	localparam logic [8:0] OFF_DREQ_NS = 9'h17c;
	localparam logic [8:0] OFF_TX_CNT = 9'h184;
	localparam logic [2:0] BANK_PORT = 3'h2;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam int HDR_CRC_LSB = 20;
	localparam int HDR_KIND_LSB = 16;
	localparam int CHK_CLR_BIT = 0;
	// ----------------------------------------
	// Message kinds and arithmetic
	// ----------------------------------------
	localparam logic [3:0] KIND_SYNC = 4'h0;
	localparam logic [3:0] KIND_DREQ = 4'h1;
	localparam logic [3:0] KIND_PDRESP = 4'h3;
	localparam logic [63:0] NS_PER_SEC = 64'h0000_0000_3b9a_ca00;
	localparam logic [11:0] CRC_POLY = 12'h80f;
	localparam int CF_FRAC_BITS = 16;
	// ----------------------------------------
	// Host controller APB map
	// ----------------------------------------
	localparam logic [11:0] HOFF_CMD = 12'h000;
	localparam logic [11:0] HOFF_WDATA = 12'h004;
	localparam logic [11:0] HOFF_RDATA = 12'h008;
	localparam logic [11:0] HOFF_STAT = 12'h00c;
	localparam logic [11:0] HOFF_CTRL = 12'h010;
	localparam logic [11:0] HOFF_IRQ_STS = 12'h014;
	localparam logic [11:0] HOFF_IRQ_MASK = 12'h018;
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_WR_BIT = 12;
	localparam int CMD_BANK_LSB = 16;
	localparam int CMD_PORT_LSB = 20;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_REFUSED = 1;
	localparam int IRQ_W = 2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} ptc_hstate_t;
endpackage

// [inc/ptc_reg_if.sv]
`timescale 1ns/100ps
interface ptc_reg_if;
	logic req;
	logic wr;
	logic [8:0] addr;
	logic [2:0] bank;
	logic [1:0] port;
	logic [31:0] wdata;
	logic ts_enable;
	logic ack;
	logic [31:0] rdata;
	modport dev (
		input req, wr, addr, bank, port, wdata, ts_enable,
		output ack, rdata
	);
	modport host (
		output req, wr, addr, bank, port, wdata, ts_enable,
		input ack, rdata
	);
endinterface

// [verilog/ptc_host_ctrl.sv]
`timescale 1ns/100ps
module ptc_host_ctrl
	import ptc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Device register port
	ptc_reg_if.host rif
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	ptc_hstate_t state_q;
	logic req_q;
	logic wr_q;
	logic [8:0] addr_q;
	logic [2:0] bank_q;
	logic [1:0] port_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic ts_en_q;
	logic [IRQ_W-1:0] sts_q;
	logic [IRQ_W-1:0] mask_q;
	logic [IRQ_W-1:0] sts_d;
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire acc = psel & penable;
	wire wr_en = acc & pwrite;
	wire hit_cmd = paddr == HOFF_CMD;
	wire hit_wd = paddr == HOFF_WDATA;
	wire hit_rd = paddr == HOFF_RDATA;
	wire hit_st = paddr == HOFF_STAT;
	wire hit_ct = paddr == HOFF_CTRL;
	wire hit_is = paddr == HOFF_IRQ_STS;
	wire hit_im = paddr == HOFF_IRQ_MASK;
	wire mapped = hit_cmd | hit_wd | hit_rd | hit_st | hit_ct | hit_is | hit_im;
	wire busy = state_q != ST_IDLE;
	wire [8:0] c_addr = pwdata[CMD_ADDR_LSB +: 9];
	wire c_wr = pwdata[CMD_WR_BIT];
	wire [2:0] c_bank = pwdata[CMD_BANK_LSB +: 3];
	wire [1:0] c_port = pwdata[CMD_PORT_LSB +: 2];
	wire try_go = wr_en & hit_cmd & ~busy;
	// Clear bit must stay put while the timestamp unit runs
	wire guarded = c_wr & (c_bank == BANK_PORT) & (c_addr == OFF_CHK_CLR) & ts_en_q;
	wire go = try_go & ~guarded;
	wire refuse = try_go & guarded;
	wire done = (state_q == ST_WAIT) & rif.ack;
	wire [IRQ_W-1:0] ev = {refuse, done};
	wire [IRQ_W-1:0] clr = (wr_en & hit_is) ? pwdata[IRQ_W-1:0] : '0;
	assign sts_d = ev | (sts_q & ~clr);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign irq = |(sts_q & mask_q);
	assign prdata = !acc ? RST_ZERO :
		hit_cmd ? {10'h000, port_q, 1'b0, bank_q, 3'h0, wr_q, 3'h0, addr_q} :
		hit_wd ? wdata_q :
		hit_rd ? rdata_q :
		hit_st ? {30'h0, ts_en_q, busy} :
		hit_ct ? {31'h0, ts_en_q} :
		hit_is ? {30'h0, sts_q} :
		hit_im ? {30'h0, mask_q} : RST_ZERO;
	// ----------------------------------------
	// Device port drive
	// ----------------------------------------
	assign rif.req = req_q;
	assign rif.wr = wr_q;
	assign rif.addr = addr_q;
	assign rif.bank = bank_q;
	assign rif.port = port_q;
	assign rif.wdata = wdata_q;
	assign rif.ts_enable = ts_en_q;
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			req_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 9'h000;
			bank_q <= 3'h0;
			port_q <= 2'h0;
			rdata_q <= RST_ZERO;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (go) begin
						// Bank and port travel with every request
						req_q <= 1'b1;
						wr_q <= c_wr;
						addr_q <= c_addr;
						bank_q <= c_bank;
						port_q <= c_port;
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (rif.ack) begin
						req_q <= 1'b0;
						if (!wr_q) begin
							rdata_q <= rif.rdata;
						end
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					req_q <= 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_q <= RST_ZERO;
			ts_en_q <= 1'b0;
			sts_q <= '0;
			mask_q <= '0;
		end else begin
			sts_q <= sts_d;
			if (wr_en & hit_wd & ~busy) begin
				wdata_q <= pwdata;
			end
			if (wr_en & hit_ct) begin
				ts_en_q <= pwdata[0];
			end
			if (wr_en & hit_im) begin
				mask_q <= pwdata[IRQ_W-1:0];
			end
		end
	end
endmodule

// [sim/ptc_link_asserts.sv]
`timescale 1ns/100ps
module ptc_link_asserts
	import ptc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic req,
	input wire logic wr,
	input wire logic [8:0] addr,
	input wire logic [2:0] bank,
	input wire logic [1:0] port,
	input wire logic [31:0] wdata,
	input wire logic ts_enable,
	input wire logic ack,
	input wire logic [31:0] rdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_ack = ack && !wr;
	property p_ans; req && !ack |=> ack; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_pulse; ack |=> !ack; endproperty
	a_pulse: assert property (p_pulse) else $error("long ack");
	property p_cause; ack |-> $past(req); endproperty
	a_cause: assert property (p_cause) else $error("stray ack");
	property p_bank; rd_ack && bank != BANK_PORT |-> rdata == RST_ZERO; endproperty
	a_bank: assert property (p_bank) else $error("bank decode");
	property p_port; rd_ack && port == 2'h3 |-> rdata == RST_ZERO; endproperty
	a_port: assert property (p_port) else $error("port decode");
	property p_ns; rd_ack && (addr == OFF_EG_NS || addr == OFF_DREQ_NS) |-> rdata[31:30] == 2'h0;
	endproperty
	a_ns: assert property (p_ns) else $error("ns top bits");
	property p_dsec; rd_ack && addr == OFF_DREQ_SEC |-> rdata[31:4] == 28'h0; endproperty
	a_dsec: assert property (p_dsec) else $error("dreq sec width");
	property p_cnt; rd_ack && addr == OFF_TX_CNT |-> rdata <= 32'h4; endproperty
	a_cnt: assert property (p_cnt) else $error("count range");
	property p_clr; rd_ack && addr == OFF_CHK_CLR |-> rdata[31:1] == 31'h0; endproperty
	a_clr: assert property (p_clr) else $error("clear reserved");
	// Guard is judged on the enable seen when the command was taken
	property p_guard; $rose(req) && wr && bank == BANK_PORT && addr == OFF_CHK_CLR |->
		!$past(ts_enable);
	endproperty
	a_guard: assert property (p_guard) else $error("guarded write sent");
endmodule

// [sim/ptp_tx_timestamp_capture_tb.sv]
`timescale 1ns/100ps
module ptp_tx_timestamp_capture_tb
	import ptc_pkg::*;
;
	typedef struct packed {logic v; logic [1:0] p; logic [31:0] s; logic [29:0] n;
		logic [3:0] k; logic [15:0] q; logic [79:0] id;} ptc_cap_t;
	typedef struct packed {logic v; logic [1:0] p; logic [3:0] k; logic ta; logic sy;
		logic [63:0] corr; logic [31:0] rs; logic [29:0] rn; logic [31:0] ts; logic [29:0] tn;} ptc_mod_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic mod_done, udp_checksum_zero, resp_valid, resp_done;
	logic [1:0] resp_port;
	logic [3:0] resp_sec;
	logic [29:0] resp_ns;
	logic [63:0] corr_out;
	ptc_cap_t cap;
	ptc_mod_t md;
	int checks, bad_count;
	ptc_reg_if rif();
	ptc_host_ctrl u_ptc_host_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .rif(rif.host));
	ptc_tx_stamp_dev #(.NPORT(3), .DEPTH(4)) u_ptc_tx_stamp_dev (.pclk, .presetn, .rif(rif.dev),
		.cap_valid(cap.v), .cap_port(cap.p), .cap_sec(cap.s), .cap_ns(cap.n), .cap_kind(cap.k),
		.cap_seq(cap.q), .cap_src_id(cap.id), .mod_valid(md.v), .mod_port(md.p), .mod_kind(md.k),
		.turnaround_insert_en(md.ta), .sync_egress_insert_en(md.sy), .mod_corr(md.corr),
		.mod_rx_sec(md.rs), .mod_rx_ns(md.rn), .mod_tx_sec(md.ts), .mod_tx_ns(md.tn), .mod_done,
		.mod_corr_out(corr_out), .udp_checksum_zero, .resp_valid, .resp_port, .resp_done,
		.resp_sec, .resp_ns);
	ptc_link_asserts u_ptc_link_asserts (.pclk, .presetn, .req(rif.req), .wr(rif.wr),
		.addr(rif.addr), .bank(rif.bank), .port(rif.port), .wdata(rif.wdata),
		.ts_enable(rif.ts_enable), .ack(rif.ack), .rdata(rif.rdata));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One idle cycle after each transfer keeps psel from two writes in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic dev_op(input logic w, input logic [8:0] a, input logic [2:0] b,
		input logic [1:0] p, input logic [31:0] d, output logic [31:0] r);
		logic [31:0] t;
		apb(1, HOFF_WDATA, d, t);
		apb(1, HOFF_CMD, {10'h0, p, 1'b0, b, 3'h0, w, 3'h0, a}, t);
		do apb(0, HOFF_STAT, 0, t); while (t[0] === 1'b1);
		apb(0, HOFF_RDATA, 0, r);
		apb(1, HOFF_IRQ_STS, 32'h1, t);
	endtask
	function automatic logic [11:0] crc12(input logic [79:0] v);
		logic [11:0] c;
		c = 12'h0;
		for (int i = 79; i >= 0; i--)
			c = {c[10:0], 1'b0} ^ ((c[11] ^ v[i]) ? CRC_POLY : 12'h0);
		return c;
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] r;
		for (int i = 0; i < 8; i++) begin
			dev_op(0, 9'h168 + 9'(i * 4), BANK_PORT, 2'h0, 0, r);
			chk("reset value", r, 0);
		end
		$display("test reset finished");
	endtask
	task automatic t_fifo();
		logic [31:0] r;
		for (int i = 0; i < 5; i++) begin
			cap <= {1'b1, 2'h1, 32'ha5a5_0007 + 32'(i), 30'h3fff_fff0 + 30'(i), 4'(i),
				16'h8000 + 16'(i), 80'h1234_5678_9abc_def0_0000 + 80'(i)};
			@(posedge pclk);
		end
		cap.v <= 0;
		@(posedge pclk);
		dev_op(0, OFF_TX_CNT, BANK_PORT, 2'h1, 0, r);
		chk("count full", r, 4);
		for (int i = 0; i < 4; i++) begin
			dev_op(0, OFF_EG_SEC, BANK_PORT, 2'h1, 0, r);
			chk("egress sec", r, 32'ha5a5_0007 + 32'(i));
			dev_op(0, OFF_EG_NS, BANK_PORT, 2'h1, 0, r);
			chk("egress ns", r, 32'h3fff_fff0 + 32'(i));
			dev_op(0, OFF_HDR, BANK_PORT, 2'h1, 0, r);
			chk("header", r, {crc12(80'h1234_5678_9abc_def0_0000 + 80'(i)), 4'(i),
				16'h8000 + 16'(i)});
			dev_op(0, OFF_TX_CNT, BANK_PORT, 2'h1, 0, r);
			chk("count after pop", r, 32'(3 - i));
		end
		dev_op(0, OFF_DREQ_SEC, BANK_PORT, 2'h1, 0, r);
		chk("dreq sec", r, 32'h8);
		dev_op(0, OFF_DREQ_NS, BANK_PORT, 2'h1, 0, r);
		chk("dreq ns", r, 32'h3fff_fff1);
		dev_op(0, OFF_DREQ_SEC, BANK_PORT, 2'h0, 0, r);
		chk("other port dreq", r, 0);
		resp_valid <= 1;
		resp_port <= 2'h1;
		@(posedge pclk);
		resp_valid <= 0;
		@(negedge pclk);
		chk("resp done", resp_done, 1);
		chk("resp time", {resp_sec, resp_ns}, {4'h8, 30'h3fff_fff1});
		// Back on the rising edge so the next bus request starts off a clean edge
		@(posedge pclk);
		$display("test capture buffer finished");
	endtask
	task automatic t_mod();
		logic [31:0] r;
		logic [3:0] k;
		logic [1:0] p;
		dev_op(1, OFF_CHK_CLR, BANK_PORT, 2'h2, 32'h1, r);
		dev_op(0, OFF_CHK_CLR, BANK_PORT, 2'h2, 0, r);
		chk("clear bit", r, 1);
		for (int i = 0; i < 16; i++) begin
			p = (i[3:2] == 2'h3) ? 2'h0 : 2'h2;
			k = (i[3:2] == 2'h0) ? KIND_SYNC : (i[3:2] == 2'h2) ? KIND_DREQ : KIND_PDRESP;
			// Rx 5 s + 999999999 ns, tx 6 s + 1 ns: a 2 ns gap across a seconds carry
			md <= {1'b1, p, k, i[0], i[1], 64'h1_0000_0000, 32'h5, 30'h3b9a_c9ff, 32'h6, 30'h1};
			@(posedge pclk);
			md.v <= 0;
			@(negedge pclk);
			chk("mod done", mod_done, 1);
			chk("checksum zero", udp_checksum_zero,
				p == 2'h2 && ((i[0] && k == KIND_PDRESP) || (i[1] && k == KIND_SYNC)));
			chk("correction", corr_out,
				(i[0] && k == KIND_PDRESP) ? 64'h1_0002_0000 : 64'h1_0000_0000);
			@(posedge pclk);
		end
		$display("test modification finished");
	endtask
	task automatic t_refuse();
		logic [31:0] r;
		apb(1, HOFF_IRQ_MASK, 32'h2, r);
		apb(1, HOFF_CTRL, 32'h1, r);
		apb(0, HOFF_STAT, 0, r);
		chk("status enabled", r, 32'h2);
		dev_op(1, OFF_CHK_CLR, BANK_PORT, 2'h2, 32'h0, r);
		chk("refused irq", irq, 1);
		apb(0, HOFF_IRQ_STS, 0, r);
		chk("refused status", r[1:0], 2'h2);
		apb(1, HOFF_IRQ_STS, 32'h2, r);
		chk("irq cleared", irq, 0);
		apb(1, HOFF_CTRL, 0, r);
		dev_op(1, OFF_CHK_CLR, 3'h3, 2'h2, 32'h0, r);
		dev_op(0, OFF_CHK_CLR, BANK_PORT, 2'h2, 0, r);
		chk("clear kept", r, 1);
		dev_op(0, OFF_CHK_CLR, 3'h3, 2'h2, 0, r);
		chk("other bank", r, 0);
		dev_op(0, OFF_CHK_CLR, BANK_PORT, 2'h3, 0, r);
		chk("absent port", r, 0);
		apb(0, 12'h020, 0, r);
		chk("unmapped error", last_err, 1);
		$display("test refusal finished");
	endtask
	// ----------------------------------------
	// Clock, sequence and watchdog
	// ----------------------------------------
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		cap = '0;
		md = '0;
		resp_valid = 0;
		resp_port = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		presetn = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset();
		t_fifo();
		t_mod();
		t_refuse();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end
endmodule
